// File: rtl/fpt_pkg.sv
// Constants, pin bundle and state encoding for the parameter word block.
// Assumes a mode 0 serial link: data in on rising, data out on falling.
package fpt_pkg;

  // Command opcodes
  localparam logic [7:0] FPT_OP_PARAM_RD = 8'h5a;
  localparam logic [7:0] FPT_OP_WE_NV = 8'h06;
  localparam logic [7:0] FPT_OP_WE_VOL = 8'h50;
  localparam logic [7:0] FPT_OP_WE_CLR = 8'h04;
  localparam logic [7:0] FPT_OP_STAT_WR = 8'h01;
  localparam logic [7:0] FPT_OP_STAT_RD = 8'h05;

  // Table placement and link framing
  localparam logic [23:0] FPT_TBL_BASE = 24'h000030;
  localparam logic [23:0] FPT_TBL_BYTES = 24'h000008;
  localparam logic [1:0] FPT_ADDR_LAST = 2'h2;
  localparam logic [2:0] FPT_BIT_LAST = 3'h7;
  localparam logic [7:0] FPT_UNMAPPED = 8'hff;

  // First word fields: low byte codes and upper default
  localparam logic [2:0] FPT_FIXED_ONES = 3'h7;
  localparam logic [1:0] FPT_ERASE_UNIFORM = 2'h1;
  localparam logic [1:0] FPT_ERASE_NONE = 2'h3;
  localparam int unsigned FPT_BUF_MIN_BYTES = 64;
  localparam logic [23:0] FPT_UPPER_DEFAULT = 24'hffffff;

  // Second word encoding
  localparam int unsigned FPT_LOG_DENSITY_MIN = 32;

  // Status byte field positions and protect bit reset value
  localparam int unsigned FPT_SR_WEL_POS = 1;
  localparam int unsigned FPT_SR_BP_LSB = 2;
  localparam logic [2:0] FPT_BP_RESET = 3'h0;

  typedef struct packed {
    logic sck;
    logic cs_b;
    logic si;
  } fpt_pin_s;

  typedef enum logic [2:0] {
    FPT_IDLE = 3'h0,
    FPT_CMD = 3'h1,
    FPT_ADDR = 3'h3,
    FPT_DUMMY = 3'h2,
    FPT_DATA = 3'h6,
    FPT_WSR = 3'h7,
    FPT_SKIP = 3'h5
  } fpt_state_e;

endpackage : fpt_pkg

// File: rtl/fpt_sync3.sv
// Three-stage synchroniser for asynchronous pin inputs.
// Assumes the inputs are slow compared with clk.
`timescale 1ns/1ps
module fpt_sync3 #(
  parameter int unsigned W = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q2,
  output logic [W-1:0] q3
);

  logic [W-1:0] q1_r;
  logic [W-1:0] q2_r;
  logic [W-1:0] q3_r;

  // Reset to the idle link levels: clock low, select high, data low
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q1_r <= W'(2);
      q2_r <= W'(2);
      q3_r <= W'(2);
    end
    else
    begin
      q1_r <= d;
      q2_r <= q1_r;
      q3_r <= q2_r;
    end
  end

  assign q2 = q2_r;
  assign q3 = q3_r;

endmodule : fpt_sync3

// File: rtl/fpt_param_words.sv
// Serial flash slave presenting two read-only parameter words.
// Assumes a mode 0 link whose clock is far slower than clk.
`timescale 1ns/1ps
module fpt_param_words #(
  parameter int unsigned DENSITY_LOG2 = 24,
  parameter bit SR_VOLATILE = 1'b1,
  parameter bit WE_SEL = 1'b1,
  parameter int unsigned BUF_BYTES = 256,
  parameter bit UNIFORM_4K = 1'b1,
  parameter logic [23:0] FEAT_UPPER = fpt_pkg::FPT_UPPER_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire fpt_pkg::fpt_pin_s pins_in,
  output logic so,
  output logic so_oe,
  output logic [2:0] bp_state
);
  import fpt_pkg::*;

  localparam logic VOL_BP = SR_VOLATILE;
  localparam logic WE_BIT = SR_VOLATILE & WE_SEL;
  localparam logic BUF_BIG = (BUF_BYTES >= FPT_BUF_MIN_BYTES);
  localparam logic [1:0] ERASE_CODE =
    UNIFORM_4K ? FPT_ERASE_UNIFORM : FPT_ERASE_NONE;
  localparam logic [31:0] WORD_ONE = {FEAT_UPPER, FPT_FIXED_ONES,
    WE_BIT, VOL_BP, BUF_BIG, ERASE_CODE};
  localparam logic [31:0] WORD_TWO = (DENSITY_LOG2 >= FPT_LOG_DENSITY_MIN)
    ? {1'b1, 31'(DENSITY_LOG2)}
    : {1'b0, 31'((64'd1 << DENSITY_LOG2) - 64'd1)};

  fpt_pin_s s2;
  fpt_pin_s s3;
  fpt_state_e state_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_r;
  logic [23:0] addr_r;
  logic [1:0] addr_cnt_r;
  logic rd_stat_r;
  logic wel_r;
  logic vwe_r;
  logic [2:0] bp_r;
  logic [2:0] bp_nv_r;
  logic [7:0] tx_r;
  logic so_r;
  logic so_oe_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic byte_done;
  logic in_cmd;
  logic wr_ok;
  logic [7:0] rx_byte;
  logic [7:0] stat_byte;
  logic [7:0] load_byte;

  fpt_sync3 #(.W($bits(fpt_pin_s))) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(pins_in),
    .q2(s2),
    .q3(s3)
  );

  // Byte of the table at a link address, little-endian within each word
  function automatic logic [7:0] tbl_byte(input logic [23:0] a);
    logic [23:0] off;
    logic [31:0] w;
    begin
      off = a - FPT_TBL_BASE;
      w = off[2] ? WORD_TWO : WORD_ONE;
      if (off < FPT_TBL_BYTES)
        tbl_byte = 8'(w >> {off[1:0], 3'h0});
      else
        tbl_byte = FPT_UNMAPPED;
    end
  endfunction : tbl_byte

  assign sck_rise = s2.sck & ~s3.sck;
  assign sck_fall = ~s2.sck & s3.sck;
  assign cs_act = ~s2.cs_b;
  assign byte_done = cs_act & sck_rise & (bit_cnt_r == FPT_BIT_LAST);
  assign in_cmd = (state_r == FPT_IDLE) || (state_r == FPT_CMD);
  assign rx_byte = {rx_r, s2.si};
  assign stat_byte = {3'h0, bp_r, wel_r, 1'b0};
  assign load_byte = rd_stat_r ? stat_byte : tbl_byte(addr_r);
  // Solely volatile parts need the one enable that bit 4 selects
  assign wr_ok = VOL_BP ? (WE_SEL ? wel_r : vwe_r) : (wel_r | vwe_r);

  // Command framing, three-byte address and read pointer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= FPT_IDLE;
      bit_cnt_r <= 3'h0;
      rx_r <= 7'h0;
      addr_r <= 24'h0;
      addr_cnt_r <= 2'h0;
      rd_stat_r <= 1'b0;
    end
    else if (!cs_act)
    begin
      state_r <= FPT_IDLE;
      bit_cnt_r <= 3'h0;
    end
    else
    begin
      if (state_r == FPT_IDLE)
        state_r <= FPT_CMD;
      if (sck_fall && state_r == FPT_DATA && bit_cnt_r == 3'h0
          && !rd_stat_r)
        addr_r <= addr_r + 24'h1;
      if (sck_rise)
      begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        rx_r <= {rx_r[5:0], s2.si};
        if (bit_cnt_r == FPT_BIT_LAST)
        begin
          case (state_r)
            FPT_IDLE, FPT_CMD:
            begin
              addr_cnt_r <= 2'h0;
              rd_stat_r <= (rx_byte == FPT_OP_STAT_RD);
              if (rx_byte == FPT_OP_PARAM_RD)
                state_r <= FPT_ADDR;
              else if (rx_byte == FPT_OP_STAT_RD)
                state_r <= FPT_DATA;
              else if (rx_byte == FPT_OP_STAT_WR)
                state_r <= FPT_WSR;
              else
                state_r <= FPT_SKIP;
            end
            FPT_ADDR:
            begin
              addr_r <= {addr_r[15:0], rx_byte};
              addr_cnt_r <= addr_cnt_r + 2'h1;
              // Always three bytes, whatever the array addressing
              if (addr_cnt_r == FPT_ADDR_LAST)
                state_r <= FPT_DUMMY;
            end
            FPT_DUMMY:
              state_r <= FPT_DATA;
            FPT_WSR:
              state_r <= FPT_SKIP;
            default:
              state_r <= state_r;
          endcase
        end
      end
    end
  end

  // Write enables and protect bits
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wel_r <= 1'b0;
      vwe_r <= 1'b0;
      bp_r <= FPT_BP_RESET;
      bp_nv_r <= FPT_BP_RESET;
    end
    else if (byte_done && in_cmd)
    begin
      if (rx_byte == FPT_OP_WE_NV)
        wel_r <= 1'b1;
      else if (rx_byte == FPT_OP_WE_VOL)
        vwe_r <= 1'b1;
      else if (rx_byte == FPT_OP_WE_CLR)
      begin
        wel_r <= 1'b0;
        vwe_r <= 1'b0;
      end
    end
    else if (byte_done && state_r == FPT_WSR)
    begin
      // Commits on the first byte; later bytes of the frame are dropped
      if (wr_ok)
      begin
        if (VOL_BP || vwe_r)
          bp_r <= rx_byte[FPT_SR_BP_LSB +: 3];
        else
        begin
          bp_r <= rx_byte[FPT_SR_BP_LSB +: 3];
          bp_nv_r <= rx_byte[FPT_SR_BP_LSB +: 3];
        end
      end
      wel_r <= 1'b0;
      vwe_r <= 1'b0;
    end
  end

  // Serial output, shifted on the link's falling edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
      tx_r <= 8'h0;
    end
    else if (!cs_act)
      so_oe_r <= 1'b0;
    else if (sck_fall && state_r == FPT_DATA)
    begin
      so_oe_r <= 1'b1;
      if (bit_cnt_r == 3'h0)
      begin
        so_r <= load_byte[7];
        tx_r <= {load_byte[6:0], 1'b0};
      end
      else
      begin
        so_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  assign so = so_r;
  assign so_oe = so_oe_r;
  assign bp_state = bp_r;

endmodule : fpt_param_words

// File: verif/fpt_monitor.sv
// Checker for the parameter word block, bound to every instance.
// Assumes only the block's ports are visible.
`timescale 1ns/1ps
module fpt_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire fpt_pkg::fpt_pin_s pins_in,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [2:0] bp_state
);
  import fpt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_reset_bp: assert property (
    disable iff (1'b0) !rst_b |=> bp_state == 3'h0)
    else $error("protect bits not cleared by reset");
  a_reset_out: assert property (
    disable iff (1'b0) !rst_b |=> !so_oe && !so)
    else $error("output driven during reset");
  a_idle_quiet: assert property (pins_in.cs_b [*5] |-> !so_oe)
    else $error("output driven while deselected");
  a_oe_start: assert property ($rose(so_oe) |->
    !$past(pins_in.cs_b, 3) && !$past(pins_in.sck, 3))
    else $error("output enabled outside a falling link edge");
  a_oe_hold: assert property (so_oe && !pins_in.cs_b |=> so_oe)
    else $error("output dropped within a frame");
  a_oe_drop: assert property ($rose(pins_in.cs_b) |-> ##[1:6] !so_oe)
    else $error("output still driven after deselect");
  a_so_on_fall: assert property (
    so_oe && $past(so_oe) && $changed(so) |-> !$past(pins_in.sck, 3))
    else $error("data changed away from a falling link edge");
  a_bp_quiet: assert property (
    pins_in.cs_b [*8] |-> $stable(bp_state))
    else $error("protect bits changed between frames");
  c_read: cover property ($rose(so_oe));
  c_bp: cover property ($changed(bp_state));
  c_drop: cover property ($fell(so_oe));
endmodule : fpt_monitor
bind fpt_param_words fpt_monitor mon (.clk(clk), .rst_b(rst_b),
  .pins_in(pins_in), .so(so), .so_oe(so_oe), .bp_state(bp_state));

// File: verif/fpt_host.sv
// Host controller model driving the link pins of the block.
// Assumes it alone drives the pins; link half period 400 ns.
`timescale 1ns/1ps
module fpt_host (
  output fpt_pkg::fpt_pin_s pins,
  input wire logic so
);
  import fpt_pkg::*;
  initial pins = 3'b010;
  // The link clock stands still low outside frames
  task start();
    pins.cs_b = 1'b0;
    #400;
  endtask : start
  task stop();
    #400;
    pins.cs_b = 1'b1;
    // Released line shows no stale bit
    pins.si = ~pins.si;
    #800;
  endtask : stop
  // MSB first; data out sampled on the rising link edge
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      pins.si = tx[i];
      #400;
      pins.sck = 1'b1;
      rx[i] = so;
      #400;
      pins.sck = 1'b0;
    end
  endtask : xfer
endmodule : fpt_host

// File: verif/fpt_param_words_test.sv
// Self-checking bench for the parameter word block, two configurations.
// Assumes the host model paces the link at an 800 ns period.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module fpt_param_words_test;
  import fpt_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sel = 1'b0;
  logic so_a, so_b;
  logic oe_a, oe_b;
  logic [7:0] feat_lo [2];
  logic [2:0] bp_a, bp_b;
  logic [7:0] r;
  int mismatches = 0;
  int num_checks = 0;
  fpt_pin_s pins;
  // A line left undriven shows the inverse of its last bit
  fpt_host host (.pins(pins),
    .so(sel ? (oe_b ? so_b : ~so_b) : (oe_a ? so_a : ~so_a)));
  fpt_param_words dut (.clk(clk), .rst_b(rst_b), .pins_in(pins), .so(so_a),
    .so_oe(oe_a), .bp_state(bp_a));
  fpt_param_words #(.DENSITY_LOG2(33), .SR_VOLATILE(1'b0), .BUF_BYTES(16),
    .UNIFORM_4K(1'b0)) dut_nv (.clk(clk), .rst_b(rst_b), .pins_in(pins),
    .so(so_b), .so_oe(oe_b), .bp_state(bp_b));
  // Bit 4 only counts when bit 3 marks the protect bits as volatile
  function automatic logic [7:0] vol_we(input logic [7:0] f);
    return (f[3] && f[4]) ? FPT_OP_WE_NV : FPT_OP_WE_VOL;
  endfunction : vol_we
  initial
    forever #50 clk = ~clk;
  task frame(input logic [7:0] op, input logic [7:0] d, input int n);
    @(posedge clk);
    #1;
    host.start();
    host.xfer(op, r);
    for (int i = 0; i < n; i++)
      host.xfer(d, r);
    host.stop();
  endtask : frame
  task rd_tbl(input logic [71:0] e);
    @(posedge clk);
    #1;
    host.start();
    host.xfer(FPT_OP_PARAM_RD, r);
    for (int i = 2; i >= 0; i--)
      host.xfer(FPT_TBL_BASE[8*i +: 8], r);
    host.xfer(8'h00, r);
    for (int i = 8; i >= 0; i--)
    begin
      host.xfer(8'h00, r);
      `CHK(r, e[8*i +: 8])
      if (i == 8)
        feat_lo[sel] = r;
    end
    `CHK(sel ? oe_b : oe_a, 1'b1)
    host.stop();
    `CHK(sel ? oe_b : oe_a, 1'b0)
  endtask : rd_tbl
  task results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial
  begin
    #1000000;
    mismatches++;
    results();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    rd_tbl(72'hfd_ffffff_ffffff00_ff);
    sel = 1'b1;
    rd_tbl(72'he3_ffffff_21000080_ff);
    frame(FPT_OP_WE_VOL, 8'h00, 0);
    frame(FPT_OP_STAT_WR, 8'h1c, 1);
    `CHK(bp_a, 3'h0)
    `CHK(bp_b, 3'h7)
    frame(FPT_OP_WE_NV, 8'h00, 0);
    sel = 1'b0;
    frame(FPT_OP_STAT_RD, 8'h00, 1);
    `CHK(r, 8'h02)
    frame(FPT_OP_STAT_WR, 8'h08, 1);
    `CHK(bp_a, 3'h2)
    `CHK(bp_b, 3'h2)
    frame(FPT_OP_WE_NV, 8'h00, 0);
    frame(FPT_OP_WE_CLR, 8'h00, 0);
    frame(FPT_OP_STAT_WR, 8'h1c, 1);
    `CHK(bp_a, 3'h2)
    `CHK(vol_we(feat_lo[1]), FPT_OP_WE_VOL)
    `CHK(feat_lo[1][1:0] == FPT_ERASE_UNIFORM, 1'b0)
    frame(vol_we(feat_lo[0]), 8'h00, 0);
    frame(FPT_OP_STAT_WR, 8'h04, 1);
    `CHK(bp_a, 3'h1)
    `CHK(bp_b, 3'h1)
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    `CHK(bp_a, 3'h0)
    results();
  end
endmodule : fpt_param_words_test
